// ### rtl/cee_defines.vh
`ifndef CEE_DEFINES_VH
`define CEE_DEFINES_VH

// register byte addresses
`define CEE_ADDR_ERRCNT      12'h000
`define CEE_ADDR_FIFOSUM     12'h004
`define CEE_ADDR_IRQ_STATUS  12'h008
`define CEE_ADDR_IRQ_MASK    12'h00c

// error-count status field positions
`define CEE_BIT_TX_BUS_OFF   21
`define CEE_BIT_TX_PASSIVE   20
`define CEE_BIT_RX_PASSIVE   19
`define CEE_BIT_TX_WARNING   18
`define CEE_BIT_RX_WARNING   17
`define CEE_BIT_ANY_WARNING  16

// fault-confinement thresholds
`define CEE_LIMIT_BUS_OFF    9'd256
`define CEE_LIMIT_PASSIVE    9'd128
`define CEE_LIMIT_WARNING    9'd96

// counter steps
`define CEE_STEP_TX_ERR      9'd8
`define CEE_STEP_RX_ERR      9'd1
`define CEE_STEP_RX_PRIMARY  9'd8
`define CEE_RX_PASSIVE_RELOAD 9'd120

// recovery: 128 runs of 11 recessive bits
`define CEE_RECOVERY_RUNS    8'd128

// interrupt status bits
`define CEE_IRQ_BUS_OFF      0
`define CEE_IRQ_PASSIVE      1
`define CEE_IRQ_WARNING      2
`define CEE_IRQ_FIFO         3
`define CEE_IRQ_WIDTH        4

`define CEE_RESET_VALUE      32'h00000000

`endif

// ### rtl/cee_error_state.v
`timescale 1ns/1ps
`default_nettype none
`include "cee_defines.vh"

// How it works
// - bus-off flag, bit 21, set while transmit error count is 256 or more.
// - transmit passive flag, bit 20, set while transmit count is 128 or more.
// - receive passive flag, bit 19, set while receive count is 128 or more.
// - transmit warning flag, bit 18, while transmit count is 96 to 127.
// - receive warning flag, bit 17, while receive count is 96 to 127.
// - combined warning flag, bit 16, is the or of both warning flags.
// - per-FIFO pending bit is high while any enabled interrupt of it pends.
module cee_error_state #(
    parameter NUM_FIFOS = 32
) (
    input  wire                 sys_clk_i,
    input  wire                 rst_n_i,
    input  wire [11:0]          paddr_i,
    input  wire                 psel_i,
    input  wire                 penable_i,
    input  wire                 pwrite_i,
    input  wire [31:0]          pwdata_i,
    output reg  [31:0]          prdata_o,
    output wire                 pready_o,
    output wire                 pslverr_o,
    input  wire                 tx_error_i,
    input  wire                 tx_ok_i,
    input  wire                 rx_error_i,
    input  wire                 rx_primary_error_i,
    input  wire                 rx_ok_i,
    input  wire                 recessive_run_i,
    input  wire [NUM_FIFOS-1:0] fifo_flag_i,
    input  wire [NUM_FIFOS-1:0] fifo_enable_i,
    output wire                 tx_bus_off_flag_o,
    output wire                 tx_error_passive_flag_o,
    output wire                 irq_o
);

    reg  [8:0]           tx_cnt_q;
    reg  [8:0]           tx_cnt_d;
    reg  [8:0]           rx_cnt_q;
    reg  [8:0]           rx_cnt_d;
    reg  [7:0]           run_cnt_q;
    reg  [7:0]           run_cnt_d;
    reg  [NUM_FIFOS-1:0] fifo_irq_pending_q;
    reg  [`CEE_IRQ_WIDTH-1:0] irq_stat_q;
    reg  [`CEE_IRQ_WIDTH-1:0] irq_mask_q;
    reg  [`CEE_IRQ_WIDTH-1:0] prev_ev_q;
    wire [`CEE_IRQ_WIDTH-1:0] ev_level;
    wire [`CEE_IRQ_WIDTH-1:0] ev_rise;
    wire                 tx_bus_off_flag;
    wire                 tx_error_passive_flag;
    wire                 rx_error_passive_flag;
    wire                 tx_warning_flag;
    wire                 rx_warning_flag;
    wire                 any_warning_flag;
    reg  [31:0]          status_word;
    reg  [31:0]          fifo_word;
    reg  [31:0]          prdata_d;
    reg  [`CEE_IRQ_WIDTH-1:0] irq_stat_d;
    reg  [`CEE_IRQ_WIDTH-1:0] irq_mask_d;
    wire                 wr_access;
    wire                 rd_setup;
    wire                 stat_wr;
    wire                 mask_wr;
    wire                 recovery_done;

    // saturating add, capped at bus-off limit
    function [8:0] sat_add;
        input [8:0] val;
        input [8:0] step;
        reg   [9:0] sum;
        begin
            sum = {1'b0, val} + {1'b0, step};
            if (sum > {1'b0, `CEE_LIMIT_BUS_OFF}) begin
                sat_add = `CEE_LIMIT_BUS_OFF;
            end else begin
                sat_add = sum[8:0];
            end
        end
    endfunction

    function in_warning;
        input [8:0] val;
        begin
            in_warning = (val >= `CEE_LIMIT_WARNING) &&
                         (val < `CEE_LIMIT_PASSIVE);
        end
    endfunction

    assign tx_bus_off_flag       = (tx_cnt_q >= `CEE_LIMIT_BUS_OFF);
    assign tx_error_passive_flag = (tx_cnt_q >= `CEE_LIMIT_PASSIVE);
    assign rx_error_passive_flag = (rx_cnt_q >= `CEE_LIMIT_PASSIVE);
    assign tx_warning_flag       = in_warning(tx_cnt_q);
    assign rx_warning_flag       = in_warning(rx_cnt_q);
    assign any_warning_flag      = tx_warning_flag | rx_warning_flag;

    assign tx_bus_off_flag_o       = tx_bus_off_flag;
    assign tx_error_passive_flag_o = tx_error_passive_flag;

    // last recessive run of recovery; clears both counts together
    assign recovery_done = tx_bus_off_flag && recessive_run_i &&
                           (run_cnt_q == `CEE_RECOVERY_RUNS - 8'h01);

    // transmit counter; bus-off holds until recovery completes
    always @* begin
        tx_cnt_d  = tx_cnt_q;
        run_cnt_d = run_cnt_q;
        if (tx_bus_off_flag) begin
            if (recessive_run_i) begin
                run_cnt_d = run_cnt_q + 8'h01;
            end
            if (recovery_done) begin
                tx_cnt_d  = 9'h000;
                run_cnt_d = 8'h00;
            end
        end else if (tx_error_i) begin
            tx_cnt_d = sat_add(tx_cnt_q, `CEE_STEP_TX_ERR);
        end else if (tx_ok_i && tx_cnt_q != 9'h000) begin
            tx_cnt_d = tx_cnt_q - 9'h001;
        end
    end

    // receive counter; leaves passive by reload to 120
    always @* begin
        rx_cnt_d = rx_cnt_q;
        if (recovery_done) begin
            rx_cnt_d = 9'h000;
        end else if (rx_primary_error_i) begin
            rx_cnt_d = sat_add(rx_cnt_q, `CEE_STEP_RX_PRIMARY);
        end else if (rx_error_i) begin
            rx_cnt_d = sat_add(rx_cnt_q, `CEE_STEP_RX_ERR);
        end else if (rx_ok_i) begin
            if (rx_cnt_q > `CEE_LIMIT_PASSIVE - 9'h001) begin
                rx_cnt_d = `CEE_RX_PASSIVE_RELOAD;
            end else if (rx_cnt_q != 9'h000) begin
                rx_cnt_d = rx_cnt_q - 9'h001;
            end
        end
    end

    // register field only 8 bits wide; bus-off shows as 0x00 plus flag
    always @* begin
        status_word = 32'h00000000;
        status_word[`CEE_BIT_TX_BUS_OFF]  = tx_bus_off_flag;
        status_word[`CEE_BIT_TX_PASSIVE]  = tx_error_passive_flag;
        status_word[`CEE_BIT_RX_PASSIVE]  = rx_error_passive_flag;
        status_word[`CEE_BIT_TX_WARNING]  = tx_warning_flag;
        status_word[`CEE_BIT_RX_WARNING]  = rx_warning_flag;
        status_word[`CEE_BIT_ANY_WARNING] = any_warning_flag;
        status_word[15:8] = tx_cnt_q[7:0];
        status_word[7:0]  = rx_cnt_q[7:0];
    end

    // unused upper bits read zero when fewer fifos are built
    always @* begin
        fifo_word = 32'h00000000;
        fifo_word[NUM_FIFOS-1:0] = fifo_irq_pending_q;
    end

    // events are rising edges of the state levels
    assign ev_level = {(|fifo_irq_pending_q), any_warning_flag,
                       tx_error_passive_flag | rx_error_passive_flag,
                       tx_bus_off_flag};
    assign ev_rise  = ev_level & ~prev_ev_q;

    assign wr_access = psel_i & penable_i & pwrite_i;
    assign rd_setup  = psel_i & ~penable_i & ~pwrite_i;
    assign pready_o  = 1'b1;
    assign pslverr_o = 1'b0;
    assign irq_o     = |(irq_stat_q & irq_mask_q);
    assign stat_wr   = wr_access && (paddr_i == `CEE_ADDR_IRQ_STATUS);
    assign mask_wr   = wr_access && (paddr_i == `CEE_ADDR_IRQ_MASK);

    // set wins over a write-one clear in the same cycle
    always @* begin
        irq_stat_d = irq_stat_q | ev_rise;
        irq_mask_d = irq_mask_q;
        if (stat_wr) begin
            irq_stat_d = (irq_stat_q &
                          ~pwdata_i[`CEE_IRQ_WIDTH-1:0]) | ev_rise;
        end
        if (mask_wr) begin
            irq_mask_d = pwdata_i[`CEE_IRQ_WIDTH-1:0];
        end
    end

    // read data captured in setup, held through the access phase
    always @* begin
        prdata_d = prdata_o;
        if (rd_setup) begin
            case (paddr_i)
                `CEE_ADDR_ERRCNT: begin
                    prdata_d = status_word;
                end
                `CEE_ADDR_FIFOSUM: begin
                    prdata_d = fifo_word;
                end
                `CEE_ADDR_IRQ_STATUS: begin
                    prdata_d = {28'h0000000, irq_stat_q};
                end
                `CEE_ADDR_IRQ_MASK: begin
                    prdata_d = {28'h0000000, irq_mask_q};
                end
                default: begin
                    prdata_d = 32'h00000000;
                end
            endcase
        end
    end

    always @(posedge sys_clk_i) begin
        if (!rst_n_i) begin
            tx_cnt_q           <= 9'h000;
            rx_cnt_q           <= 9'h000;
            run_cnt_q          <= 8'h00;
            fifo_irq_pending_q <= {NUM_FIFOS{1'b0}};
            irq_stat_q         <= {`CEE_IRQ_WIDTH{1'b0}};
            irq_mask_q         <= {`CEE_IRQ_WIDTH{1'b0}};
            prev_ev_q          <= {`CEE_IRQ_WIDTH{1'b0}};
            prdata_o           <= `CEE_RESET_VALUE;
        end else begin
            tx_cnt_q  <= tx_cnt_d;
            rx_cnt_q  <= rx_cnt_d;
            run_cnt_q <= run_cnt_d;
            fifo_irq_pending_q <= fifo_flag_i & fifo_enable_i;
            prev_ev_q  <= ev_level;
            irq_stat_q <= irq_stat_d;
            irq_mask_q <= irq_mask_d;
            prdata_o   <= prdata_d;
        end
    end

endmodule
`default_nettype wire

// ### bench/cee_error_state_chk.sv
`timescale 1ns/1ps
`default_nettype none
module cee_error_state_chk (
    input wire sys_clk_i,
    input wire rst_n_i,
    input wire pready_o,
    input wire pslverr_o,
    input wire tx_error_i,
    input wire tx_ok_i,
    input wire recessive_run_i,
    input wire tx_bus_off_flag_o,
    input wire tx_error_passive_flag_o,
    input wire irq_o
);
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_off_is_passive : assert property (
        tx_bus_off_flag_o |-> tx_error_passive_flag_o) else $error("off");
    a_off_rise_cause : assert property (
        $rose(tx_bus_off_flag_o) |-> $past(tx_error_i)) else $error("rise");
    a_off_held : assert property (
        tx_bus_off_flag_o && !recessive_run_i |=> tx_bus_off_flag_o)
        else $error("bus-off left without recovery");
    a_off_fall_cause : assert property (
        $fell(tx_bus_off_flag_o) |-> $past(recessive_run_i))
        else $error("bus-off fell without recovery run");
    a_pass_rise_cause : assert property (
        $rose(tx_error_passive_flag_o) |-> $past(tx_error_i))
        else $error("passive rose without tx error");
    a_pass_fall_cause : assert property (
        $fell(tx_error_passive_flag_o) |->
        $past(tx_ok_i) || $past(recessive_run_i)) else $error("passive fell");
    a_reset_quiet : assert property (
        $rose(rst_n_i) |-> !tx_error_passive_flag_o && !irq_o)
        else $error("flags set after reset");
    a_bus_answer : assert property (
        pready_o && !pslverr_o) else $error("bus answer wrong");
endmodule
`default_nettype wire

// ### bench/cee_can_node.sv
`timescale 1ns/1ps
`default_nettype none
// bus events: 0 tx err, 1 tx ok, 2 rx err, 3 rx primary, 4 rx ok, 5 run
module cee_can_node (
    input  wire logic       sys_clk_i,
    output logic      [5:0] ev_o
);
    initial ev_o = 6'h00;
    // one idle cycle between pulses keeps each event a separate count
    task automatic fire(input int k, input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            ev_o[k] <= 1'b1;
            @(posedge sys_clk_i);
            ev_o[k] <= 1'b0;
        end
    endtask
endmodule
`default_nettype wire

// ### bench/cee_error_state_tb.sv
`timescale 1ns/1ps
`default_nettype none
module cee_error_state_tb;
    logic        sys_clk_i = 0, rst_n_i = 0, psel = 0, pen = 0, pwr = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, fflag = 32'h0, fen = 32'h0, prdata, rd;
    logic        pready, pslverr, irq, bo, bp;
    logic [5:0]  ev;
    int          n_fail = 0, n_checks = 0, cyc = 0;
    cee_can_node node (.sys_clk_i(sys_clk_i), .ev_o(ev));
    cee_error_state uut (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i),
        .paddr_i(paddr), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .tx_error_i(ev[0]), .tx_ok_i(ev[1]),
        .rx_error_i(ev[2]), .rx_primary_error_i(ev[3]), .rx_ok_i(ev[4]),
        .recessive_run_i(ev[5]), .fifo_flag_i(fflag), .fifo_enable_i(fen),
        .tx_bus_off_flag_o(bo), .tx_error_passive_flag_o(bp), .irq_o(irq));
    initial forever #5 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_fail++;
            report_and_stop;
        end
    end
    task report_and_stop;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task chk(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge sys_clk_i);
        psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
        @(posedge sys_clk_i);
        pen <= 1'b1;
        do @(posedge sys_clk_i); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0; pen <= 1'b0;
    endtask
    task rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk($sformatf("reg %h", a), rd, exp);
    endtask
    function logic [31:0] stat(input logic [8:0] t, r);
        logic tw, rw;
        tw = t >= 9'h060 && t < 9'h080;
        rw = r >= 9'h060 && r < 9'h080;
        return {10'h0, t >= 9'h100, t >= 9'h080, r >= 9'h080, tw, rw,
                tw | rw, t[7:0], r[7:0]};
    endfunction
    task irqchk(input logic e);
        @(negedge sys_clk_i);
        chk("irq", {31'h0, irq}, {31'h0, e});
    endtask
    initial begin
        repeat (10) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        rdchk(12'h000, 32'h0);
        rdchk(12'h004, 32'h0);
        apb(1'b1, 12'h00c, 32'hf);
        node.fire(0, 12); rdchk(12'h000, stat(9'd96, 9'd0));
        irqchk(1'b1);
        rdchk(12'h008, 32'h4);
        apb(1'b1, 12'h008, 32'hf); irqchk(1'b0);
        rdchk(12'h008, 32'h0);
        node.fire(1, 1); rdchk(12'h000, stat(9'd95, 9'd0));
        node.fire(0, 5); rdchk(12'h000, stat(9'd135, 9'd0));
        node.fire(0, 16); rdchk(12'h000, stat(9'd256, 9'd0));
        chk("flags", {30'h0, bo, bp}, 32'h3);
        node.fire(5, 128); rdchk(12'h000, stat(9'd0, 9'd0));
        node.fire(3, 12); rdchk(12'h000, stat(9'd0, 9'd96));
        node.fire(2, 32); rdchk(12'h000, stat(9'd0, 9'd128));
        node.fire(4, 1); rdchk(12'h000, stat(9'd0, 9'd120));
        apb(1'b1, 12'h000, 32'hffffffff);
        rdchk(12'h000, stat(9'd0, 9'd120));
        rdchk(12'h010, 32'h0);
        fflag <= 32'hf0f000ff; fen <= 32'h0ff00f0f;
        @(posedge sys_clk_i);
        rdchk(12'h004, 32'h00f0000f);
        fen <= 32'h0;
        @(posedge sys_clk_i);
        rdchk(12'h004, 32'h0);
        apb(1'b1, 12'h00c, 32'h0); irqchk(1'b0);
        report_and_stop;
    end
endmodule
bind cee_error_state cee_error_state_chk u_chk (.sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i), .pready_o(pready_o), .pslverr_o(pslverr_o),
    .tx_error_i(tx_error_i), .tx_ok_i(tx_ok_i),
    .recessive_run_i(recessive_run_i), .tx_bus_off_flag_o(tx_bus_off_flag_o),
    .tx_error_passive_flag_o(tx_error_passive_flag_o), .irq_o(irq_o));
`default_nettype wire
